// ===== bench/jpe_monitor.sv
// Checker for the four scan-link wires between programmer and device.
// Assumes tck is divided from pclk with a half period of at least 8 pclk.
`timescale 1ns/1ns

module jpe_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    typedef struct packed {
        logic [2:0] tlr;
        logic       tck;
        logic       tms_r;
    } jpe_mon_st_t;

    jpe_mon_st_t st_q;
    jpe_mon_st_t st_d;

    // Counts rising tck with tms high, saturating at five
    always_comb begin
        st_d = st_q;
        st_d.tck = tck;
        if (tck && !st_q.tck) begin
            st_d.tms_r = tms;
            st_d.tlr = !tms ? 3'h0 : (st_q.tlr == 3'h5 ? 3'h5 : st_q.tlr + 3'h1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tms_moves_low: assert property ($changed(tms) |-> !tck)
        else $error("tms changed while tck high");
    a_tdi_moves_low: assert property ($changed(tdi) |-> !tck)
        else $error("tdi changed while tck high");
    a_tck_high_len: assert property ($rose(tck) |-> tck [*8])
        else $error("tck high phase too short");
    a_tck_low_len: assert property ($fell(tck) |-> !tck [*8])
        else $error("tck low phase too short");
    a_tdo_steady: assert property (tck && $past(tck) && tdo_oe && $past(tdo_oe) |-> $stable(tdo))
        else $error("tdo moved while tck high");
    a_oe_reset_state: assert property (st_q.tlr == 3'h5 |-> !tdo_oe)
        else $error("tdo driven in test logic reset");
    a_oe_rise_shift: assert property ($rose(tdo_oe) |-> !tck && !st_q.tms_r)
        else $error("tdo drive began outside a shift entry");
    a_oe_fall_exit: assert property ($fell(tdo_oe) |-> !tck && st_q.tms_r)
        else $error("tdo drive ended outside a shift exit");

    c_shift: cover property ($rose(tdo_oe));
    c_reset_state: cover property (st_q.tlr == 3'h5);
    c_tdi_one: cover property ($rose(tck) && tdi);
endmodule : jpe_monitor

// ===== bench/tb_top.sv
// Self-checking bench: both ends joined by the scan link, driven over APB.
// Assumes the programmer register map of jpe_cfg.svh; references come from the model below.
`timescale 1ns/1ns
`include "jpe_cfg.svh"

module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        fuse, ext_n, dis_set, dis_bit, core_rst, prog_md, pm_m;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, tx;
    logic [15:0] sig_m;
    int          n_fail, cmp_count, cyc, i, len;

    jpe_if link ();
    jpe_dev #(.STARTUP_CYC(16'd200)) u_jpe_dev (.pclk(pclk), .presetn(presetn), .link(link),
        .scan_port_enable_fuse(fuse), .ext_reset_n(ext_n), .disable_set(dis_set),
        .scan_port_disable_bit(dis_bit), .core_reset(core_rst), .prog_mode(prog_md));
    jpe_prog u_jpe_prog (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    jpe_monitor u_jpe_monitor (.pclk(pclk), .presetn(presetn), .tck(link.tck),
        .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .tdo_oe(link.tdo_oe));

    task automatic results;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One full instruction and data scan, then fetch what came back
    task automatic op(input logic [3:0] ir, input int n, input logic [31:0] d);
        int k;
        apb(1'b1, `JPE_OFF_TX, d);
        apb(1'b1, `JPE_OFF_CTRL, {1'b1, 22'h0, 5'(n), ir});
        rd = 32'h1;
        for (k = 0; k < 3000 && rd[0]; k++) apb(1'b0, `JPE_OFF_STAT, 32'h0);
        apb(1'b0, `JPE_OFF_RX, 32'h0);
    endtask : op

    function automatic logic [31:0] msk(input int n);
        return 32'((64'd1 << (n + 1)) - 64'd1);
    endfunction : msk

    // One-bit chain model: c0 leaves first, then each bit one shift late
    function automatic logic [31:0] chain1(input logic [31:0] t, input int n, input logic c0);
        logic [31:0] r;
        logic        fifo [$];
        r = 32'h0;
        fifo.push_back(c0);
        for (int k = 0; k <= n; k++) begin
            fifo.push_back(t[k]);
            r[k] = fifo.pop_front();
        end
        return r;
    endfunction : chain1

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, dis_set} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fuse = 1'b1;
        ext_n = 1'b1;
        sig_m = 16'h0000;
        void'($urandom(88994));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        apb(1'b0, `JPE_OFF_CTRL, 32'h0);
        chk("ctrl_reset", 32'h0000_000F, rd);
        // Every code other than the two chains acts as bypass
        for (i = 0; i < 16; i++) begin
            if (i == 4 || i == 12) continue;
            tx = $urandom();
            len = $urandom_range(31);
            op(4'(i), len, tx);
            chk("bypass_rx", chain1(tx, len, 1'b0), rd & msk(len));
            apb(1'b0, `JPE_OFF_CTRL, 32'h0);
            chk("ctrl_rd", {23'h0, 5'(len), 4'(i)}, rd);
        end
        // Reset chain, then scans while the core is held
        chk("core_idle", 32'h0, {31'h0, core_rst});
        op(4'hC, 0, 32'h1);
        chk("rst_rx0", chain1(32'h1, 0, 1'b0), rd & 32'h1);
        chk("core_on", 32'h1, {31'h0, core_rst});
        tx = $urandom();
        op(4'hF, 31, tx);
        chk("byp_in_rst", chain1(tx, 31, 1'b0), rd);
        op(4'hC, 2, 32'h2);
        chk("rst_rx", chain1(32'h2, 2, 1'b1), rd & 32'h7);
        chk("core_hold", 32'h1, {31'h0, core_rst});
        repeat (60) @(posedge pclk);
        chk("core_hold2", 32'h1, {31'h0, core_rst});
        repeat (150) @(posedge pclk);
        chk("core_off", 32'h0, {31'h0, core_rst});
        // Core held through the reset chain before program entry
        op(4'hC, 0, 32'h1);
        chk("pe_rst_rx", chain1(32'h1, 0, 1'b0), rd & 32'h1);
        chk("pe_core_on", 32'h1, {31'h0, core_rst});
        // Signature: wrong, right, right in upper half, partial shift
        for (i = 0; i < 4; i++) begin
            len = (i == 2) ? 31 : ((i == 3) ? 7 : 15);
            tx = $urandom();
            if (i == 1 || i == 2) tx[len -: 16] = `JPE_SIG_EXPECT;
            op(4'h4, len, tx);
            sig_m = 16'({tx, sig_m} >> (len + 1));
            pm_m = (sig_m == `JPE_SIG_EXPECT);
            chk("prog_mode", {31'h0, pm_m}, {31'h0, prog_md});
        end
        op(4'hC, 0, 32'h0);
        chk("rst_kept", chain1(32'h0, 0, 1'b1), rd & 32'h1);
        // Port closed by fuse, then by the disable bit
        fuse <= 1'b0;
        op(4'hC, 0, 32'h1);
        chk("fuse_off", 32'h0, {31'h0, core_rst});
        chk("fuse_rx", 32'h1, rd & 32'h1);
        fuse <= 1'b1;
        @(posedge pclk);
        dis_set <= 1'b1;
        @(posedge pclk);
        dis_set <= 1'b0;
        op(4'hC, 0, 32'h1);
        chk("dis_on", 32'h1, {31'h0, dis_bit});
        chk("dis_rx", 32'h1, rd & 32'h1);
        chk("dis_core", 32'h0, {31'h0, core_rst});
        chk("dis_pm", {31'h0, pm_m}, {31'h0, prog_md});
        ext_n <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("dis_hold", 32'h1, {31'h0, dis_bit});
        repeat (6) @(posedge pclk);
        chk("dis_clr", 32'h0, {31'h0, dis_bit});
        chk("ext_core", 32'h1, {31'h0, core_rst});
        ext_n <= 1'b1;
        tx = $urandom();
        op(4'hF, 31, tx);
        chk("reenabled", chain1(tx, 31, 1'b0), rd);
        results();
    end
endmodule : tb_top

// ===== src/jpe_cfg.svh
// Constants for the scan-port programming entry pair.
// Assumes inclusion by bare name from both ends and the package.
`ifndef JPE_CFG_SVH
`define JPE_CFG_SVH

// Instruction register
`define JPE_IR_W            4
`define JPE_IR_PART_RESET   4'hC
`define JPE_IR_PROG_ENTRY   4'h4
`define JPE_IR_BYPASS       4'hF
`define JPE_IR_CAPTURE      4'h1

// Data registers
`define JPE_SIG_W           16
`define JPE_SIG_EXPECT      16'h5A5A

// Disable-bit clear delay and core start-up delay, chip clocks
`define JPE_DIS_CLR_CYC     2'd2
`define JPE_STARTUP_CYC     16'h0010

// Synchroniser lanes on the device: tck, tms, tdi, ext reset
`define JPE_SYNC_W          4
`define JPE_LANE_TCK        0
`define JPE_LANE_TMS        1
`define JPE_LANE_TDI        2
`define JPE_LANE_RST        3

// Clock timing
`define JPE_CLK_NS          4
`define JPE_TCK_NS          128

// Programmer register map, byte addresses
`define JPE_OFF_CTRL        8'h00
`define JPE_OFF_TX          8'h04
`define JPE_OFF_RX          8'h08
`define JPE_OFF_STAT        8'h0C
`define JPE_CTRL_GO         31
`define JPE_CTRL_LEN_LSB    4
`define JPE_CTRL_LEN_MSB    8

// Tms sequences, sent lsb first
`define JPE_HEAD_PAT        10'h0DF
`define JPE_HEAD_LEN        6'd10
`define JPE_MID_PAT         10'h003
`define JPE_MID_LEN         6'd4
`define JPE_TAIL_PAT        10'h001
`define JPE_TAIL_LEN        6'd2

`endif

// ===== src/jpe_dev.sv
// Device end: test access port with part-reset and program-entry chains.
// Assumes pclk is far faster than tck; all link pins are sampled on pclk.
`timescale 1ns/1ns
`include "jpe_cfg.svh"

// Summary of operation
// - Programmer needs only the four link pins
// - Port works only with fuse set, disable clear
// - Reset low clears disable bit after two clocks
// - Reset re-enable unusable for scan or debug
// - Programmer keeps tck below chip frequency
// - All chains shift lsb in and out first
// - Instruction register is four bits wide
// - Loaded instruction picks the data chain
// - Run-Test/Idle makes clocks; also parking state; here it only parks
// - Code 0xC selects one-bit reset chain
// - Part reset leaves the test port alone
// - Reset chain shifts in Shift-DR on tck
// - Code 0x4 selects sixteen-bit signature chain
// - Signature shifted in through tdi in Shift-DR
// - Update-DR enters programming only on match
// - Reset chain acts as reset pin, with timeout
// - Programmer resets part before programming entry
module jpe_dev #(
    parameter logic [15:0]           STARTUP_CYC = `JPE_STARTUP_CYC,
    parameter logic [`JPE_SIG_W-1:0] SIG_EXPECT  = `JPE_SIG_EXPECT
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Link
    jpe_if.dev        link,
    // Core side
    input  wire logic scan_port_enable_fuse,
    input  wire logic ext_reset_n,
    input  wire logic disable_set,
    output logic      scan_port_disable_bit,
    output logic      core_reset,
    output logic      prog_mode
);

    function automatic jpe_pkg::jpe_tap_t tap_next(
        input jpe_pkg::jpe_tap_t st,
        input logic              tms
    );
        case (st)
            jpe_pkg::TAP_TLR:   tap_next = tms ? jpe_pkg::TAP_TLR   : jpe_pkg::TAP_RTI;
            jpe_pkg::TAP_RTI:   tap_next = tms ? jpe_pkg::TAP_SELDR : jpe_pkg::TAP_RTI;
            jpe_pkg::TAP_SELDR: tap_next = tms ? jpe_pkg::TAP_SELIR : jpe_pkg::TAP_CAPDR;
            jpe_pkg::TAP_CAPDR: tap_next = tms ? jpe_pkg::TAP_EX1DR : jpe_pkg::TAP_SHDR;
            jpe_pkg::TAP_SHDR:  tap_next = tms ? jpe_pkg::TAP_EX1DR : jpe_pkg::TAP_SHDR;
            jpe_pkg::TAP_EX1DR: tap_next = tms ? jpe_pkg::TAP_UPDR  : jpe_pkg::TAP_PSDR;
            jpe_pkg::TAP_PSDR:  tap_next = tms ? jpe_pkg::TAP_EX2DR : jpe_pkg::TAP_PSDR;
            jpe_pkg::TAP_EX2DR: tap_next = tms ? jpe_pkg::TAP_UPDR  : jpe_pkg::TAP_SHDR;
            jpe_pkg::TAP_UPDR:  tap_next = tms ? jpe_pkg::TAP_SELDR : jpe_pkg::TAP_RTI;
            jpe_pkg::TAP_SELIR: tap_next = tms ? jpe_pkg::TAP_TLR   : jpe_pkg::TAP_CAPIR;
            jpe_pkg::TAP_CAPIR: tap_next = tms ? jpe_pkg::TAP_EX1IR : jpe_pkg::TAP_SHIR;
            jpe_pkg::TAP_SHIR:  tap_next = tms ? jpe_pkg::TAP_EX1IR : jpe_pkg::TAP_SHIR;
            jpe_pkg::TAP_EX1IR: tap_next = tms ? jpe_pkg::TAP_UPIR  : jpe_pkg::TAP_PSIR;
            jpe_pkg::TAP_PSIR:  tap_next = tms ? jpe_pkg::TAP_EX2IR : jpe_pkg::TAP_PSIR;
            jpe_pkg::TAP_EX2IR: tap_next = tms ? jpe_pkg::TAP_UPIR  : jpe_pkg::TAP_SHIR;
            jpe_pkg::TAP_UPIR:  tap_next = tms ? jpe_pkg::TAP_SELDR : jpe_pkg::TAP_RTI;
            default:            tap_next = jpe_pkg::TAP_TLR;
        endcase
    endfunction : tap_next

    // Serial output of the chain picked by the instruction
    function automatic logic dr_out(input jpe_pkg::jpe_dev_st_t s);
        if (s.ir == `JPE_IR_PART_RESET) begin
            dr_out = s.rst_chain;
        end else if (s.ir == `JPE_IR_PROG_ENTRY) begin
            dr_out = s.sig[0];
        end else begin
            dr_out = s.byp;
        end
    endfunction : dr_out

    localparam jpe_pkg::jpe_dev_st_t RST_ST = '{
        s1:        '0,
        s2:        '0,
        s3:        '0,
        f:         '0,
        tap:       jpe_pkg::TAP_TLR,
        ir:        `JPE_IR_BYPASS,
        irsh:      `JPE_IR_BYPASS,
        byp:       1'b0,
        rst_chain: 1'b0,
        sig:       '0,
        prog:      1'b0,
        dis:       1'b0,
        dis_cnt:   2'd0,
        core_rst:  1'b1,
        su_cnt:    STARTUP_CYC,
        tdo:       1'b0,
        tdo_oe:    1'b0
    };

    jpe_pkg::jpe_dev_st_t q;
    jpe_pkg::jpe_dev_st_t d;

    logic tck_rise;
    logic tck_fall;
    logic tms_v;
    logic tdi_v;
    logic ext_low;
    logic port_en;
    logic rst_hold;

    always_comb begin
        d = q;
        // Three-stage sync; a level counts once stages two and three agree
        d.s1 = {ext_reset_n, link.tdi, link.tms, link.tck};
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < `JPE_SYNC_W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.f[i] = q.s3[i];
            end
        end
        tck_rise = !q.f[`JPE_LANE_TCK] && d.f[`JPE_LANE_TCK];
        tck_fall = q.f[`JPE_LANE_TCK] && !d.f[`JPE_LANE_TCK];
        tms_v    = d.f[`JPE_LANE_TMS];
        tdi_v    = d.f[`JPE_LANE_TDI];
        ext_low  = !d.f[`JPE_LANE_RST];

        // Disable bit: reset pin low clears it after two chip clocks
        if (q.dis && ext_low) begin
            if (q.dis_cnt == `JPE_DIS_CLR_CYC - 2'd1) begin
                d.dis     = 1'b0;
                d.dis_cnt = 2'd0;
            end else begin
                d.dis_cnt = q.dis_cnt + 2'd1;
            end
        end else begin
            d.dis_cnt = 2'd0;
        end
        if (disable_set) begin
            d.dis = 1'b1;
        end

        port_en = scan_port_enable_fuse && !q.dis;

        if (!port_en) begin
            d.tap    = jpe_pkg::TAP_TLR;
            d.ir     = `JPE_IR_BYPASS;
            d.tdo_oe = 1'b0;
        end else if (tck_rise) begin
            case (q.tap)
                jpe_pkg::TAP_TLR: begin
                    d.ir = `JPE_IR_BYPASS;
                end
                jpe_pkg::TAP_CAPIR: begin
                    d.irsh = `JPE_IR_CAPTURE;
                end
                jpe_pkg::TAP_SHIR: begin
                    d.irsh = {tdi_v, q.irsh[`JPE_IR_W-1:1]};
                end
                jpe_pkg::TAP_UPIR: begin
                    d.ir = q.irsh;
                end
                jpe_pkg::TAP_CAPDR: begin
                    d.byp = 1'b0;
                end
                jpe_pkg::TAP_SHDR: begin
                    if (q.ir == `JPE_IR_PART_RESET) begin
                        d.rst_chain = tdi_v;
                    end else if (q.ir == `JPE_IR_PROG_ENTRY) begin
                        d.sig = {tdi_v, q.sig[`JPE_SIG_W-1:1]};
                    end else begin
                        d.byp = tdi_v;
                    end
                end
                jpe_pkg::TAP_UPDR: begin
                    if (q.ir == `JPE_IR_PROG_ENTRY) begin
                        d.prog = (q.sig == SIG_EXPECT);
                    end
                end
                default: begin
                end
            endcase
            // Run-Test/Idle is a plain parking state here
            d.tap = tap_next(q.tap, tms_v);
        end else if (tck_fall) begin
            d.tdo_oe = (q.tap == jpe_pkg::TAP_SHIR) || (q.tap == jpe_pkg::TAP_SHDR);
            if (q.tap == jpe_pkg::TAP_SHIR) begin
                d.tdo = q.irsh[0];
            end else begin
                d.tdo = dr_out(q);
            end
        end

        // Core reset: chain or pin, then start-up timeout; TAP untouched
        rst_hold = q.rst_chain || ext_low;
        if (rst_hold) begin
            d.core_rst = 1'b1;
            d.su_cnt   = STARTUP_CYC;
        end else if (q.su_cnt != 16'h0000) begin
            d.su_cnt = q.su_cnt - 16'h0001;
        end else begin
            d.core_rst = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= RST_ST;
        end else begin
            q <= d;
        end
    end

    assign link.tdo              = q.tdo;
    assign link.tdo_oe           = q.tdo_oe;
    assign scan_port_disable_bit = q.dis;
    assign core_reset            = q.core_rst;
    assign prog_mode             = q.prog;

endmodule : jpe_dev

// ===== src/jpe_if.sv
// Four-wire scan link between the programmer and the device.
// Assumes a pull-up on tdo: a reader takes tdo_oe low as a high level.
`timescale 1ns/1ns

interface jpe_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;

    modport dev (
        input  tck,
        input  tms,
        input  tdi,
        output tdo,
        output tdo_oe
    );

    modport prog (
        output tck,
        output tms,
        output tdi,
        input  tdo,
        input  tdo_oe
    );
endinterface : jpe_if

// ===== src/jpe_pkg.sv
// Types shared by both ends of the scan-port programming link.
// Assumes jpe_cfg.svh is on the include path.
`include "jpe_cfg.svh"

package jpe_pkg;

    typedef enum logic [15:0] {
        TAP_TLR   = 16'h0001,
        TAP_RTI   = 16'h0002,
        TAP_SELDR = 16'h0004,
        TAP_CAPDR = 16'h0008,
        TAP_SHDR  = 16'h0010,
        TAP_EX1DR = 16'h0020,
        TAP_PSDR  = 16'h0040,
        TAP_EX2DR = 16'h0080,
        TAP_UPDR  = 16'h0100,
        TAP_SELIR = 16'h0200,
        TAP_CAPIR = 16'h0400,
        TAP_SHIR  = 16'h0800,
        TAP_EX1IR = 16'h1000,
        TAP_PSIR  = 16'h2000,
        TAP_EX2IR = 16'h4000,
        TAP_UPIR  = 16'h8000
    } jpe_tap_t;

    typedef enum logic [5:0] {
        PH_IDLE = 6'h01,
        PH_HEAD = 6'h02,
        PH_IR   = 6'h04,
        PH_MID  = 6'h08,
        PH_DR   = 6'h10,
        PH_TAIL = 6'h20
    } jpe_phase_t;

    typedef struct packed {
        logic [`JPE_SYNC_W-1:0] s1;
        logic [`JPE_SYNC_W-1:0] s2;
        logic [`JPE_SYNC_W-1:0] s3;
        logic [`JPE_SYNC_W-1:0] f;
        jpe_tap_t               tap;
        logic [`JPE_IR_W-1:0]   ir;
        logic [`JPE_IR_W-1:0]   irsh;
        logic                   byp;
        logic                   rst_chain;
        logic [`JPE_SIG_W-1:0]  sig;
        logic                   prog;
        logic                   dis;
        logic [1:0]             dis_cnt;
        logic                   core_rst;
        logic [15:0]            su_cnt;
        logic                   tdo;
        logic                   tdo_oe;
    } jpe_dev_st_t;

    typedef struct packed {
        logic [2:0]  s;
        logic        tdo_f;
        jpe_phase_t  ph;
        logic [5:0]  cnt;
        logic [9:0]  pat;
        logic [3:0]  ir;
        logic [4:0]  len;
        logic [31:0] tx;
        logic [31:0] rx;
        logic        go;
        logic [7:0]  div;
        logic        tck;
        logic        tms;
        logic        tdi;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } jpe_prog_st_t;

endpackage : jpe_pkg

// ===== src/jpe_prog.sv
// Programmer end: APB-controlled sequencer that loads an instruction,
// then shifts one data chain of 1..32 bits, capturing tdo.
// Assumes tck half period well above the device's sampling latency.
`timescale 1ns/1ns
`include "jpe_cfg.svh"

module jpe_prog #(
    parameter logic [7:0] TCK_HALF = 8'(`JPE_TCK_NS / (2 * `JPE_CLK_NS))
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Link
    jpe_if.prog              link
);

    jpe_pkg::jpe_prog_st_t q;
    jpe_pkg::jpe_prog_st_t d;

    logic rise;
    logic fall;
    logic busy;
    logic wr;

    always_comb begin
        d = q;
        busy = (q.ph != jpe_pkg::PH_IDLE) || q.go;
        // Tdo sync, counted once stages two and three agree
        // Released tdo reads high through the pull-up
        d.s = {q.s[1:0], link.tdo_oe ? link.tdo : 1'b1};
        if (q.s[1] == q.s[2]) begin
            d.tdo_f = q.s[2];
        end

        // APB: pready in the first access cycle, data registered in setup
        d.pready  = psel && !penable && !q.pready;
        d.pslverr = 1'b0;
        if (psel && !penable) begin
            d.prdata = 32'h0000_0000;
            if (paddr == `JPE_OFF_CTRL) begin
                d.prdata = {23'h00_0000, q.len, q.ir};
            end else if (paddr == `JPE_OFF_TX) begin
                d.prdata = q.tx;
            end else if (paddr == `JPE_OFF_RX) begin
                d.prdata = q.rx;
            end else if (paddr == `JPE_OFF_STAT) begin
                d.prdata = {31'h0000_0000, busy};
            end else begin
                d.pslverr = 1'b1;
            end
        end
        wr = psel && penable && q.pready && pwrite && !q.pslverr;
        if (wr && paddr == `JPE_OFF_CTRL && !busy) begin
            d.ir  = pwdata[`JPE_IR_W-1:0];
            d.len = pwdata[`JPE_CTRL_LEN_MSB:`JPE_CTRL_LEN_LSB];
            d.go  = pwdata[`JPE_CTRL_GO];
        end else if (wr && paddr == `JPE_OFF_TX && !busy) begin
            d.tx = pwdata;
        end

        // Tck divider, driven out by this end
        rise = 1'b0;
        fall = 1'b0;
        if (q.div == TCK_HALF - 8'd1) begin
            d.div = 8'd0;
            d.tck = !q.tck;
            rise  = !q.tck;
            fall  = q.tck;
        end else begin
            d.div = q.div + 8'd1;
        end

        // Tdo sampled on the rising edge, lsb first
        if (rise && q.ph == jpe_pkg::PH_DR) begin
            d.rx[q.cnt[4:0]] = q.tdo_f;
        end

        // New tms and tdi presented on the falling edge
        if (fall) begin
            case (q.ph)
                jpe_pkg::PH_IDLE: begin
                    if (q.go) begin
                        d.go  = 1'b0;
                        d.ph  = jpe_pkg::PH_HEAD;
                        d.cnt = 6'd0;
                        d.pat = `JPE_HEAD_PAT;
                        d.rx  = 32'h0000_0000;
                    end
                end
                jpe_pkg::PH_HEAD: begin
                    if (q.cnt == `JPE_HEAD_LEN - 6'd1) begin
                        d.ph  = jpe_pkg::PH_IR;
                        d.cnt = 6'd0;
                    end else begin
                        d.cnt = q.cnt + 6'd1;
                        d.pat = {1'b0, q.pat[9:1]};
                    end
                end
                jpe_pkg::PH_IR: begin
                    if (q.cnt == 6'(`JPE_IR_W - 1)) begin
                        d.ph  = jpe_pkg::PH_MID;
                        d.cnt = 6'd0;
                        d.pat = `JPE_MID_PAT;
                    end else begin
                        d.cnt = q.cnt + 6'd1;
                    end
                end
                jpe_pkg::PH_MID: begin
                    if (q.cnt == `JPE_MID_LEN - 6'd1) begin
                        d.ph  = jpe_pkg::PH_DR;
                        d.cnt = 6'd0;
                    end else begin
                        d.cnt = q.cnt + 6'd1;
                        d.pat = {1'b0, q.pat[9:1]};
                    end
                end
                jpe_pkg::PH_DR: begin
                    if (q.cnt[4:0] == q.len) begin
                        d.ph  = jpe_pkg::PH_TAIL;
                        d.cnt = 6'd0;
                        d.pat = `JPE_TAIL_PAT;
                    end else begin
                        d.cnt = q.cnt + 6'd1;
                    end
                end
                jpe_pkg::PH_TAIL: begin
                    if (q.cnt == `JPE_TAIL_LEN - 6'd1) begin
                        d.ph  = jpe_pkg::PH_IDLE;
                        d.cnt = 6'd0;
                    end else begin
                        d.cnt = q.cnt + 6'd1;
                        d.pat = {1'b0, q.pat[9:1]};
                    end
                end
                default: begin
                    d.ph = jpe_pkg::PH_IDLE;
                end
            endcase
            // Pin values from the new position; idle parks in Run-Test/Idle
            d.tms = 1'b0;
            d.tdi = 1'b0;
            if (d.ph == jpe_pkg::PH_IR) begin
                d.tdi = q.ir[d.cnt[1:0]];
                d.tms = (d.cnt == 6'(`JPE_IR_W - 1));
            end else if (d.ph == jpe_pkg::PH_DR) begin
                d.tdi = q.tx[d.cnt[4:0]];
                d.tms = (d.cnt[4:0] == q.len);
            end else if (d.ph != jpe_pkg::PH_IDLE) begin
                d.tms = d.pat[0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q     <= '0;
            q.ph  <= jpe_pkg::PH_IDLE;
            q.ir  <= `JPE_IR_BYPASS;
            q.len <= 5'd0;
        end else begin
            q <= d;
        end
    end

    // Only three link pins are driven (tck, tms, tdi); no reset or clock pin of the part
    assign link.tck = q.tck;
    assign link.tms = q.tms;
    assign link.tdi = q.tdi;
    assign prdata   = q.prdata;
    assign pready   = q.pready;
    assign pslverr  = q.pslverr;

endmodule : jpe_prog
